// ===== logic/cmc_regs.vh
// Register offsets, field positions, reset values and timing counts of the CAN main mode control block.
`ifndef CMC_REGS_VH
`define CMC_REGS_VH
`define CMC_ADDR_W          8
`define CMC_MAIN_CTRL_OFS   8'h00
`define CMC_MAIN_STAT_OFS   8'h04
`define CMC_CTRL_RESET      32'h00010002
`define CMC_CTRL_WMASK      32'h0001807F
`define CMC_BIT_INIT        0
`define CMC_BIT_SLEEP       1
`define CMC_BIT_TXPRIO      2
`define CMC_BIT_RXLOCK      3
`define CMC_BIT_NORETX      4
`define CMC_BIT_AUTOWAKE    5
`define CMC_BIT_AUTOBOFF    6
`define CMC_BIT_SRST        15
`define CMC_BIT_DBGFRZ      16
`define CMC_BIT_INITACK     0
`define CMC_BIT_SLEEPACK    1
`define CMC_BIT_BUSOFF      2
`define CMC_RECESSIVE_RUN   4'hB
`define CMC_RECOVERY_RUNS   8'h80
`define CMC_SRST_CYCLES     3'h4
`endif

// ===== logic/cmc_run_counter.v
// Counts runs of consecutive recessive bits to time the bus-off recovery.
`include "cmc_regs.vh"
module cmc_run_counter #(
   parameter RUN_LEN  = `CMC_RECESSIVE_RUN,
   parameter RUN_CNT  = `CMC_RECOVERY_RUNS
) (
   input  wire core_clk,     // Block clock.
   input  wire reset_n,      // Asynchronous reset, active low.
   input  wire clear,        // Restarts both counts.
   input  wire enable,       // Counting allowed.
   input  wire bitTick,      // One pulse per bit time.
   input  wire rxLevel,      // Sampled bus level, high is recessive.
   output reg  done_ff       // Enough recessive runs seen.
);
   reg  [3:0] bitCnt_ff;
   reg  [7:0] runCnt_ff;
   // Last counts of a run and of the run total, cut to the counter widths on purpose.
   localparam [3:0] LAST_BIT = RUN_LEN - 1;
   localparam [7:0] LAST_RUN = RUN_CNT - 1;
   wire       runEnd = (bitCnt_ff == LAST_BIT);

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bitCnt_ff <= 4'h0;
         runCnt_ff <= 8'h00;
         done_ff   <= 1'b0;
      end else if (clear || !enable) begin
         bitCnt_ff <= 4'h0;
         runCnt_ff <= 8'h00;
         done_ff   <= 1'b0;
      end else if (bitTick && !done_ff) begin
         // A dominant bit restarts the current run only.
         if (!rxLevel) begin
            bitCnt_ff <= 4'h0;
         end else if (runEnd) begin
            bitCnt_ff <= 4'h0;
            runCnt_ff <= runCnt_ff + 8'h01;
            if (runCnt_ff == LAST_RUN) begin
               done_ff <= 1'b1;
            end
         end else begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
         end
      end
   end
endmodule

// ===== logic/cmc_main_mode_control.v
// Main mode control of the CAN controller: control register, mode sequencing and bus-off recovery.
`include "cmc_regs.vh"
module cmc_main_mode_control #(
   parameter ADDR_W   = `CMC_ADDR_W,
   parameter RUN_LEN  = `CMC_RECESSIVE_RUN,
   parameter RUN_CNT  = `CMC_RECOVERY_RUNS
) (
   input  wire              core_clk,        // Block clock, 250 MHz.
   input  wire              reset_n,         // Asynchronous reset, active low.
   input  wire [ADDR_W-1:0] regAddr,         // Register byte address.
   input  wire [31:0]       regWdata,        // Write data.
   input  wire              regWr,           // Write strobe.
   input  wire              regRd,           // Read strobe.
   output reg  [31:0]       regRdata_ff,     // Read data, valid the cycle after a read.
   input  wire              bitTick,         // One pulse per bus bit time.
   input  wire              rxLevel,         // Sampled receive pin, high is recessive.
   input  wire              frameStart,      // Start of frame seen on the receive input.
   input  wire              busOffEnter,     // Error logic reports entry to bus-off.
   input  wire              coreHalted,      // CPU halted for debugging.
   input  wire              busIdle,         // Protocol engine idle, safe to change mode.
   output reg               txPrioOrder_ff,  // High: send by request order, low: by identifier.
   output reg               rxOverrunLock_ff,// High: discard new frame on overrun.
   output reg               retxDisable_ff,  // High: attempt each frame once.
   output reg               busEnable_ff,    // High: protocol engine may use the bus.
   output reg               coreReset_ff,    // High: controller core held in reset.
   output reg               initModeAck_ff,  // In initialization mode.
   output reg               sleepModeAck_ff, // In sleep mode.
   output reg               busOff_ff        // In bus-off.
);
   localparam ST_SLEEP = 2'b00;
   localparam ST_INIT  = 2'b01;
   localparam ST_RUN   = 2'b10;

   reg  [31:0] ctrl_ff;
   reg  [31:0] nxt_ctrl;
   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg  [2:0]  srstCnt_ff;
   reg         initSeen_ff;
   reg         initCleared_ff;
   wire        recoverDone;

   function isAddr;
      input [ADDR_W-1:0] a;
      input [ADDR_W-1:0] ofs;
      begin
         isAddr = (a == ofs);
      end
   endfunction

   wire wrCtrl   = regWr && isAddr(regAddr, `CMC_MAIN_CTRL_OFS);
   wire init_mode_request  = ctrl_ff[`CMC_BIT_INIT];
   wire sleep_mode_request = ctrl_ff[`CMC_BIT_SLEEP];
   wire autoWake = ctrl_ff[`CMC_BIT_AUTOWAKE];
   wire autoBoff = ctrl_ff[`CMC_BIT_AUTOBOFF];
   wire srstBusy = (srstCnt_ff != 3'h0);
   // Frozen while the core is halted with freeze set; registers stay reachable.
   wire busEnableFrozen = ctrl_ff[`CMC_BIT_DBGFRZ] && coreHalted;

   // Control register; a hardware wake clear beats a software write of the same cycle.
   always @* begin
      nxt_ctrl = ctrl_ff;
      if (wrCtrl) begin
         nxt_ctrl = regWdata & `CMC_CTRL_WMASK;
      end
      if (autoWake && sleepModeAck_ff && frameStart) begin
         nxt_ctrl[`CMC_BIT_SLEEP] = 1'b0;
      end
      if (srstBusy) begin
         nxt_ctrl = `CMC_CTRL_RESET;
         nxt_ctrl[`CMC_BIT_SRST] = (srstCnt_ff != 3'h1);
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff    <= `CMC_CTRL_RESET;
         srstCnt_ff <= 3'h0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         // Soft reset holds the core for a few cycles then drops the bit by itself.
         if (srstBusy) begin
            srstCnt_ff <= srstCnt_ff - 3'h1;
         end else if (wrCtrl && regWdata[`CMC_BIT_SRST]) begin
            srstCnt_ff <= `CMC_SRST_CYCLES;
         end
      end
   end

   // Mode sequencing; init has priority over sleep, only changes out of normal mode wait for an idle bus.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SLEEP: begin
            if (init_mode_request) begin
               nxt_state = ST_INIT;
            end else if (!sleep_mode_request) begin
               nxt_state = ST_RUN;
            end
         end
         ST_INIT: begin
            if (!init_mode_request) begin
               nxt_state = sleep_mode_request ? ST_SLEEP : ST_RUN;
            end
         end
         ST_RUN: begin
            if (init_mode_request && busIdle) begin
               nxt_state = ST_INIT;
            end else if (sleep_mode_request && busIdle) begin
               nxt_state = ST_SLEEP;
            end
         end
         default: begin
            nxt_state = ST_SLEEP;
         end
      endcase
      if (srstBusy) begin
         nxt_state = ST_SLEEP;
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_SLEEP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Manual recovery: an init request must be set and later cleared while bus-off.
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         busOff_ff      <= 1'b0;
         initSeen_ff    <= 1'b0;
         initCleared_ff <= 1'b0;
      end else if (srstBusy) begin
         busOff_ff      <= 1'b0;
         initSeen_ff    <= 1'b0;
         initCleared_ff <= 1'b0;
      end else begin
         if (busOffEnter) begin
            busOff_ff <= 1'b1;
         end else if (recoverDone) begin
            busOff_ff <= 1'b0;
         end
         if (!busOff_ff) begin
            initSeen_ff    <= 1'b0;
            initCleared_ff <= 1'b0;
         end else if (init_mode_request) begin
            initSeen_ff <= 1'b1;
         end else if (initSeen_ff) begin
            initCleared_ff <= 1'b1;
         end
      end
   end

   cmc_run_counter #(
      .RUN_LEN (RUN_LEN),
      .RUN_CNT (RUN_CNT)
   ) uRunCounter (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clear    (busOffEnter || srstBusy),
      .enable   (busOff_ff && (autoBoff || initCleared_ff) && !busEnableFrozen),
      .bitTick  (bitTick),
      .rxLevel  (rxLevel),
      .done_ff  (recoverDone)
   );

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         txPrioOrder_ff   <= 1'b0;
         rxOverrunLock_ff <= 1'b0;
         retxDisable_ff   <= 1'b0;
         busEnable_ff     <= 1'b0;
         coreReset_ff     <= 1'b0;
         initModeAck_ff   <= 1'b0;
         sleepModeAck_ff  <= 1'b1;
      end else begin
         txPrioOrder_ff   <= ctrl_ff[`CMC_BIT_TXPRIO];
         rxOverrunLock_ff <= ctrl_ff[`CMC_BIT_RXLOCK];
         retxDisable_ff   <= ctrl_ff[`CMC_BIT_NORETX];
         busEnable_ff     <= (state_ff == ST_RUN) && !busEnableFrozen && !srstBusy;
         coreReset_ff     <= srstBusy;
         initModeAck_ff   <= (state_ff == ST_INIT);
         sleepModeAck_ff  <= (state_ff == ST_SLEEP);
      end
   end

   // Read port; unmapped addresses read zero.
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata_ff <= 32'h00000000;
      end else if (regRd) begin
         if (isAddr(regAddr, `CMC_MAIN_CTRL_OFS)) begin
            regRdata_ff <= ctrl_ff & `CMC_CTRL_WMASK;
         end else if (isAddr(regAddr, `CMC_MAIN_STAT_OFS)) begin
            regRdata_ff <= {29'h00000000, busOff_ff, sleepModeAck_ff, initModeAck_ff};
         end else begin
            regRdata_ff <= 32'h00000000;
         end
      end else begin
         regRdata_ff <= 32'h00000000;
      end
   end
endmodule

// ===== sim/cmc_main_mode_control_monitor.sv
// Assertion checker for the main mode control ports.
module cmc_main_mode_control_monitor #(
   parameter ADDR_W  = 8,
   parameter RUN_LEN = 11,
   parameter RUN_CNT = 128
) (
   input logic              core_clk,        // Clock.
   input logic              reset_n,         // Reset.
   input logic [ADDR_W-1:0] regAddr,         // Address.
   input logic [31:0]       regWdata,        // Data.
   input logic              regWr,           // Write.
   input logic              regRd,           // Read.
   input logic [31:0]       regRdata_ff,     // Read data.
   input logic              txPrioOrder_ff,  // Order mode.
   input logic              busEnable_ff,    // Bus use.
   input logic              coreReset_ff,    // Soft reset.
   input logic              initModeAck_ff,  // Init mode.
   input logic              sleepModeAck_ff  // Sleep mode.
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence ctrlWr;
      regWr && regAddr == 8'h00 && !regWdata[15] && !coreReset_ff;
   endsequence
   sequence srstHold;
      coreReset_ff[*4] ##1 !coreReset_ff;
   endsequence
   AST_RDZERO: assert property (!$past(regRd) |-> regRdata_ff == 32'h0)
      else $error("read data outside slot");
   AST_RSVD: assert property ($past(regRd && regAddr == 8'h00) |-> !(regRdata_ff & 32'hFFFE7F80))
      else $error("reserved bit read as one");
   AST_STAT: assert property ($past(regRd && regAddr == 8'h04)
      |-> regRdata_ff[1:0] == $past({sleepModeAck_ff, initModeAck_ff})) else $error("status mismatch");
   AST_PRIO: assert property (ctrlWr |-> ##2 txPrioOrder_ff == $past(regWdata[2], 2))
      else $error("priority mode not taken");
   AST_INIT: assert property (ctrlWr ##0 regWdata[0] |-> ##[1:4] initModeAck_ff)
      else $error("init not entered");
   AST_RUN: assert property (ctrlWr ##0 regWdata[1:0] == 2'h0
      |-> ##[1:4] !initModeAck_ff && !sleepModeAck_ff) else $error("normal mode not entered");
   AST_SRST: assert property ($rose(coreReset_ff) |-> srstHold)
      else $error("soft reset length wrong");
   AST_BUSEN: assert property (busEnable_ff |-> !initModeAck_ff && !sleepModeAck_ff)
      else $error("bus enabled outside normal mode");
endmodule
bind cmc_main_mode_control cmc_main_mode_control_monitor #(.ADDR_W(ADDR_W), .RUN_LEN(RUN_LEN), .RUN_CNT(RUN_CNT))
   monitor (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata_ff(regRdata_ff), .txPrioOrder_ff(txPrioOrder_ff), .busEnable_ff(busEnable_ff),
   .coreReset_ff(coreReset_ff), .initModeAck_ff(initModeAck_ff), .sleepModeAck_ff(sleepModeAck_ff));

// ===== sim/cmc_bus_node.sv
// Behavioural CAN node behind the transceiver.
module cmc_bus_node #(
   parameter TICK_DIV = 4
) (
   input  logic core_clk,  // Clock.
   input  logic reset_n,   // Reset.
   input  logic idleRun,   // Recessive bits.
   input  logic sendFrame, // Frame request.
   output logic bitTick,   // Bit pulse.
   output logic rxLevel,   // High is recessive.
   output logic frameStart // Frame start.
);
   int divCnt;
   // Ticks stop outside bit streams, so an idle node never feeds the recovery count.
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         divCnt <= 0;
         bitTick <= 1'b0;
         rxLevel <= 1'b0;
         frameStart <= 1'b0;
      end else begin
         divCnt <= (idleRun && divCnt < TICK_DIV - 1) ? divCnt + 1 : 0;
         bitTick <= idleRun && divCnt == TICK_DIV - 1;
         rxLevel <= idleRun;
         frameStart <= sendFrame;
      end
   end
endmodule

// ===== sim/testbench.sv
// Self-checking bench of the CAN main mode control block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, reset_n, regWr, regRd, coreHalted, idleRun, sendFrame, busOffEnter;
   logic [7:0]  regAddr;
   logic [31:0] regWdata, regRdata_ff;
   logic        txPrio, rxLock, retxDis, busEn, initAck, sleepAck, busOff, bitTick, rxLevel, frameStart, coreRst;
   int          errors = 0, compares = 0, cycles = 0;
   cmc_main_mode_control #(.RUN_LEN(2), .RUN_CNT(2)) DUT (.core_clk(core_clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff),
      .bitTick(bitTick), .rxLevel(rxLevel), .frameStart(frameStart), .busOffEnter(busOffEnter),
      .coreHalted(coreHalted), .busIdle(1'b1), .txPrioOrder_ff(txPrio), .rxOverrunLock_ff(rxLock),
      .retxDisable_ff(retxDis), .busEnable_ff(busEn), .coreReset_ff(coreRst), .initModeAck_ff(initAck),
      .sleepModeAck_ff(sleepAck), .busOff_ff(busOff));
   cmc_bus_node node (.core_clk(core_clk), .reset_n(reset_n), .idleRun(idleRun), .sendFrame(sendFrame),
      .bitTick(bitTick), .rxLevel(rxLevel), .frameStart(frameStart));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 chk(regRdata_ff & m, exp);
      @(posedge core_clk);
   endtask
   task automatic pulse(input logic boff);
      busOffEnter <= boff;
      sendFrame <= !boff;
      @(posedge core_clk);
      busOffEnter <= 1'b0;
      sendFrame <= 1'b0;
   endtask
   // Long enough for the reduced recovery count with ticks to spare.
   task automatic bits;
      idleRun <= 1'b1;
      repeat (60) @(posedge core_clk);
      idleRun <= 1'b0;
      wt(3);
   endtask
   task automatic checkReset;
      chk(32'({busEn, sleepAck, initAck}), 32'h2);
      rd(8'h00, 32'h00010002);
      rd(8'h04, 32'h00000002);
      rd(8'h08, 32'h0);
   endtask
   task automatic checkConfig;
      wr(8'h00, 32'hFFFF7FFF);
      wt(3);
      chk(32'({txPrio, rxLock, retxDis, initAck, sleepAck, busEn}), 32'h3C);
      rd(8'h00, 32'h0001007F);
      wr(8'h00, 32'h0);
      wt(3);
      chk(32'({txPrio, rxLock, retxDis, initAck, sleepAck, busEn}), 32'h01);
   endtask
   task automatic checkFreeze;
      wr(8'h00, 32'h00010000);
      coreHalted <= 1'b1;
      wt(3);
      chk(32'(busEn), 32'h0);
      rd(8'h00, 32'h00010000);
      coreHalted <= 1'b0;
      wt(3);
      chk(32'(busEn), 32'h1);
   endtask
   task automatic checkWake;
      wr(8'h00, 32'h2);
      wt(3);
      pulse(1'b0);
      wt(4);
      chk(32'(sleepAck), 32'h1);
      wr(8'h00, 32'h22);
      pulse(1'b0);
      wt(4);
      chk(32'(sleepAck), 32'h0);
      rd(8'h00, 32'h20);
   endtask
   task automatic checkBusOff;
      wr(8'h00, 32'h40);
      pulse(1'b1);
      wt(3);
      chk(32'(busOff), 32'h1);
      bits();
      chk(32'(busOff), 32'h0);
      wr(8'h00, 32'h0);
      pulse(1'b1);
      bits();
      chk(32'(busOff), 32'h1);
      wr(8'h00, 32'h1);
      wt(3);
      wr(8'h00, 32'h0);
      bits();
      chk(32'(busOff), 32'h0);
   endtask
   task automatic checkSoftReset;
      wr(8'h00, 32'h0000801C);
      wt(0);
      chk(32'(coreRst), 32'h1);
      rd(8'h00, 32'h00008000, 32'h00008000);
      wt(6);
      chk(32'(coreRst), 32'h0);
      rd(8'h00, 32'h00010002);
      chk(32'({txPrio, rxLock, retxDis, sleepAck, busEn}), 32'h02);
   endtask
   initial begin
      {reset_n, regWr, regRd, coreHalted, idleRun, sendFrame, busOffEnter} = 7'h00;
      regAddr = 8'h00;
      regWdata = 32'h0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      checkReset();
      checkConfig();
      checkFreeze();
      checkWake();
      checkBusOff();
      checkSoftReset();
      end_sim();
   end
endmodule
